// ===== rtl/ppc_protect_ctrl.sv
// Functional notes
// (R1) The discharge drive turns on only by controller command and is forced off on short circuit or discharge overcurrent.
// (R2) The charge drive turns on only by controller command and is forced off on charge overcurrent.
// (R3) With load monitoring enabled, a load input below threshold clears the load fail flag.
// (R4) The analog multiplexer select follows the value the controller writes.
// (R5) The thermistor supply is on only during a temperature selection unless a control bit holds it on.
// (R6) The thermistor supply is also on while any short circuit or overcurrent flag is set.
// (R7) External over temperature is shown when the thermistor input is below one thirteenth of the supply.
// (R8) Wake is edge triggered, rising with polarity 1 and falling with polarity 0.
// (R9) The wake status bit is the wake level, true above threshold for polarity 1, below for polarity 0.
// (R10) The device is a serial target; the controller drives the clock and data is two-way on one line.
// (R11) The discharge trip level field resets to code zero, the lowest threshold.
// (R12) Short circuit and overcurrent flags stay set until the controller clears them, holding the drives off.
module ppc_protect_ctrl #(
  parameter logic [6:0] DEV_ADDR = ppc_pkg::DEV_ADDR_DFLT
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic short_circuit_cmp_i,
  input wire logic discharge_overcurrent_cmp_i,
  input wire logic charge_overcurrent_cmp_i,
  input wire logic load_monitor_input_low_i,
  input wire logic thermistor_input_low_i,
  input wire logic wake_input_i,
  output logic discharge_switch_drive_o,
  output logic charge_switch_drive_o,
  output logic load_monitor_enable_o,
  output logic [3:0] analog_mux_select_o,
  output logic thermistor_supply_out_o,
  output logic [1:0] discharge_trip_level_o,
  output logic over_temp_o,
  output logic wake_status_o,
  output logic wake_event_o,
  output logic short_circuit_flag_o,
  output logic discharge_overcurrent_flag_o,
  output logic charge_overcurrent_flag_o,
  output logic load_fail_flag_o
);

  // ****************************************
  // declarations
  // ****************************************
  ppc_reg_if bus ();

  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic wake_prev_reg;
  logic [4:0] ctrl_reg;
  logic [3:0] mux_reg;
  logic [1:0] trip_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic load_fail_flag_reg;
  logic dis_reg;
  logic chg_reg;
  logic tsup_reg;
  logic ot_reg;
  logic wstat_reg;
  logic wevt_reg;
  logic sc_s;
  logic doc_s;
  logic coc_s;
  logic load_low_s;
  logic therm_low_s;
  logic wake_s;
  logic dis_trip;
  logic [2:0] flag_clr;
  logic [2:0] flag_set;
  logic temp_sel;

  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
    wr_hit = en && (a == off);
  endfunction

  // ****************************************
  // serial target
  // ****************************************
  ppc_i2c_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .bus(bus.target)
  );

  // ****************************************
  // comparator and pin synchronisers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {wake_input_i, thermistor_input_low_i, load_monitor_input_low_i,
                    charge_overcurrent_cmp_i, discharge_overcurrent_cmp_i, short_circuit_cmp_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign sc_s = sync2_reg[0];
  assign doc_s = sync2_reg[1];
  assign coc_s = sync2_reg[2];
  assign load_low_s = sync2_reg[3];
  assign therm_low_s = sync2_reg[4];
  assign wake_s = sync2_reg[5];
  assign dis_trip = sc_s | doc_s;
  assign flag_set = {coc_s, doc_s, sc_s};
  assign flag_clr = wr_hit(bus.wr_en, bus.addr, ppc_pkg::REG_STATUS) ? bus.wdata[2:0] : 3'h0;
  assign temp_sel = mux_reg >= ppc_pkg::MUX_TEMP_FIRST;

  // ****************************************
  // control registers
  // ****************************************
  // a trip also drops the on command so a fresh write is needed
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= ppc_pkg::CTRL_RST;
    end else begin
      if (wr_hit(bus.wr_en, bus.addr, ppc_pkg::REG_CTRL)) begin
        ctrl_reg <= bus.wdata[ppc_pkg::CTRL_W-1:0];
      end
      if (dis_trip || flags_reg[ppc_pkg::ST_SC] || flags_reg[ppc_pkg::ST_DOC]) begin
        ctrl_reg[ppc_pkg::CTRL_DIS_ON] <= 1'b0; // R1
      end
      if (coc_s || flags_reg[ppc_pkg::ST_COC]) begin
        ctrl_reg[ppc_pkg::CTRL_CHG_ON] <= 1'b0; // R2
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mux_reg <= ppc_pkg::MUX_RST;
    end else if (wr_hit(bus.wr_en, bus.addr, ppc_pkg::REG_MUX)) begin
      mux_reg <= bus.wdata[3:0]; // R4
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      trip_reg <= ppc_pkg::TRIP_RST; // R11
    end else if (wr_hit(bus.wr_en, bus.addr, ppc_pkg::REG_TRIP)) begin
      trip_reg <= bus.wdata[1:0];
    end
  end

  // ****************************************
  // fault flags
  // ****************************************
  // set wins over a clear in the same cycle
  assign flags_next = (flags_reg & ~flag_clr) | flag_set; // R12

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      flags_reg <= 3'h0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      load_fail_flag_reg <= 1'b0;
    end else if (dis_trip) begin
      load_fail_flag_reg <= 1'b1;
    end else if (ctrl_reg[ppc_pkg::CTRL_LDMON] && load_low_s) begin
      load_fail_flag_reg <= 1'b0; // R3
    end
  end

  // ****************************************
  // switch drives
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      dis_reg <= 1'b0;
      chg_reg <= 1'b0;
    end else begin
      dis_reg <= ctrl_reg[ppc_pkg::CTRL_DIS_ON] & ~dis_trip & ~load_fail_flag_reg
                 & ~flags_reg[ppc_pkg::ST_SC] & ~flags_reg[ppc_pkg::ST_DOC]; // R1
      chg_reg <= ctrl_reg[ppc_pkg::CTRL_CHG_ON] & ~coc_s & ~flags_reg[ppc_pkg::ST_COC]; // R2
    end
  end

  // ****************************************
  // thermistor supply and over temperature
  // ****************************************
  // comparator result is meaningless while the divider is unpowered
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      tsup_reg <= 1'b0;
      ot_reg <= 1'b0;
    end else begin
      tsup_reg <= temp_sel | ctrl_reg[ppc_pkg::CTRL_TSUP] // R5
                  | (|flags_next); // R6
      ot_reg <= tsup_reg & therm_low_s; // R7
    end
  end

  // ****************************************
  // wake detect
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wake_prev_reg <= 1'b0;
      wstat_reg <= 1'b0;
      wevt_reg <= 1'b0;
    end else begin
      wake_prev_reg <= wake_s;
      wstat_reg <= ctrl_reg[ppc_pkg::CTRL_WPOL] ? wake_s : ~wake_s; // R9
      wevt_reg <= ctrl_reg[ppc_pkg::CTRL_WPOL] ? (wake_s & ~wake_prev_reg)
                                                : (~wake_s & wake_prev_reg); // R8
    end
  end

  // ****************************************
  // read back
  // ****************************************
  always_comb begin
    unique case (bus.addr)
      ppc_pkg::REG_CTRL: bus.rdata = {3'h0, ctrl_reg};
      ppc_pkg::REG_MUX: bus.rdata = {4'h0, mux_reg};
      ppc_pkg::REG_TRIP: bus.rdata = {6'h00, trip_reg};
      ppc_pkg::REG_STATUS: bus.rdata = {2'h0, ot_reg, wstat_reg, load_fail_flag_reg, flags_reg};
      default: bus.rdata = 8'h00;
    endcase
  end

  assign discharge_switch_drive_o = dis_reg;
  assign charge_switch_drive_o = chg_reg;
  assign load_monitor_enable_o = ctrl_reg[ppc_pkg::CTRL_LDMON];
  assign analog_mux_select_o = mux_reg;
  assign thermistor_supply_out_o = tsup_reg;
  assign discharge_trip_level_o = trip_reg;
  assign over_temp_o = ot_reg;
  assign wake_status_o = wstat_reg;
  assign wake_event_o = wevt_reg;
  assign short_circuit_flag_o = flags_reg[ppc_pkg::ST_SC];
  assign discharge_overcurrent_flag_o = flags_reg[ppc_pkg::ST_DOC];
  assign charge_overcurrent_flag_o = flags_reg[ppc_pkg::ST_COC];
  assign load_fail_flag_o = load_fail_flag_reg;

  // ****************************************
  // checks
  // ****************************************
  AST_DIS_OFF_ON_TRIP: assert property ( // R1
    @(posedge sys_clk_i) disable iff (!rstn_i)
    dis_trip |=> !discharge_switch_drive_o)
    else $error("discharge drive on after trip");

  AST_DIS_ON_BY_CMD: assert property ( // R1
    @(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(discharge_switch_drive_o) |-> $past(ctrl_reg[ppc_pkg::CTRL_DIS_ON]))
    else $error("discharge drive on without command");

  AST_CHG_OFF_ON_TRIP: assert property ( // R2
    @(posedge sys_clk_i) disable iff (!rstn_i)
    coc_s |=> !charge_switch_drive_o [*2])
    else $error("charge drive on after trip");

  AST_LOAD_FAIL_FLAG_RELEASE: assert property ( // R3
    @(posedge sys_clk_i) disable iff (!rstn_i)
    load_fail_flag_reg && ctrl_reg[ppc_pkg::CTRL_LDMON] && load_low_s && !dis_trip
    |=> !load_fail_flag_o)
    else $error("load fail not released");

  AST_MUX_FOLLOWS: assert property ( // R4
    @(posedge sys_clk_i) disable iff (!rstn_i)
    wr_hit(bus.wr_en, bus.addr, ppc_pkg::REG_MUX)
    |=> analog_mux_select_o == $past(bus.wdata[3:0]))
    else $error("mux select not taken");

  AST_TSUP_IDLE_OFF: assert property ( // R5
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !temp_sel && !ctrl_reg[ppc_pkg::CTRL_TSUP] && flags_next == 3'h0
    |=> !thermistor_supply_out_o)
    else $error("thermistor supply on while idle");

  AST_TSUP_ON_FLAG: assert property ( // R6
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (|flag_set) |=> thermistor_supply_out_o && (|flags_reg))
    else $error("thermistor supply off with flag set");

  AST_OVER_TEMP: assert property ( // R7
    @(posedge sys_clk_i) disable iff (!rstn_i)
    thermistor_supply_out_o && therm_low_s |=> over_temp_o)
    else $error("over temperature missed");

  AST_WAKE_FALL: assert property ( // R8
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !ctrl_reg[ppc_pkg::CTRL_WPOL] && $fell(wake_s) |=> wake_event_o ##1 !wake_event_o)
    else $error("falling wake edge missed");

  AST_WAKE_LEVEL: assert property ( // R9
    @(posedge sys_clk_i) disable iff (!rstn_i)
    ctrl_reg[ppc_pkg::CTRL_WPOL] && !wake_s && $stable(ctrl_reg) |=> !wake_status_o)
    else $error("wake status wrong level");

  AST_TRIP_RESET: assert property ( // R11
    @(posedge sys_clk_i)
    !rstn_i |=> discharge_trip_level_o == 2'h0)
    else $error("trip level reset value wrong");

  AST_FLAG_STICKY: assert property ( // R12
    @(posedge sys_clk_i) disable iff (!rstn_i)
    short_circuit_flag_o && !flag_clr[ppc_pkg::ST_SC]
    |=> short_circuit_flag_o && !discharge_switch_drive_o)
    else $error("short flag dropped without clear");

endmodule // ppc_protect_ctrl

// ===== rtl/ppc_pkg.sv
package ppc_pkg;
  // ****************************************
  // register pointers seen over the serial port
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MUX = 8'h01;
  localparam logic [7:0] REG_TRIP = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_DIS_ON = 0;
  localparam int CTRL_CHG_ON = 1;
  localparam int CTRL_LDMON = 2;
  localparam int CTRL_TSUP = 3;
  localparam int CTRL_WPOL = 4;
  localparam int CTRL_W = 5;
  localparam int ST_SC = 0;
  localparam int ST_DOC = 1;
  localparam int ST_COC = 2;
  localparam int ST_LDF = 3;
  localparam int ST_WAKE = 4;
  localparam int ST_OT = 5;
  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [3:0] MUX_RST = 4'h0;
  localparam logic [3:0] MUX_TEMP_FIRST = 4'h8;
  localparam logic [1:0] TRIP_RST = 2'h0;
  // arbitrary target address
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h28;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// ===== rtl/ppc_reg_if.sv
interface ppc_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport target(output wr_en, output addr, output wdata, input rdata);
  modport regs(input wr_en, input addr, input wdata, output rdata);
endinterface

// ===== rtl/ppc_i2c_target.sv
module ppc_i2c_target #(
  parameter logic [6:0] DEV_ADDR = ppc_pkg::DEV_ADDR_DFLT
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  ppc_reg_if.target bus
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_TXACK = 5'b10000
  } ppc_i2c_e;

  ppc_i2c_e state_reg;
  logic [2:0] scl_reg;
  logic [2:0] sda_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic [1:0] phase_reg;
  logic rw_reg;
  logic nack_reg;
  logic [7:0] ptr_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic oe_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      scl_reg <= 3'h7;
      sda_reg <= 3'h7;
    end else begin
      scl_reg <= {scl_reg[1:0], scl_i};
      sda_reg <= {sda_reg[1:0], sda_i};
    end
  end

  assign scl_rise = scl_reg[1] & ~scl_reg[2];
  assign scl_fall = ~scl_reg[1] & scl_reg[2];
  assign start_cond = scl_reg[1] & scl_reg[2] & sda_reg[2] & ~sda_reg[1];
  assign stop_cond = scl_reg[1] & scl_reg[2] & ~sda_reg[2] & sda_reg[1];

  // ****************************************
  // byte engine
  // ****************************************
  // open drain: only ever pulls low, oe high while pulling
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      phase_reg <= 2'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      ptr_reg <= 8'h00;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= ST_RX;
        cnt_reg <= 4'h0;
        phase_reg <= 2'h0;
        oe_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        oe_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_reg[1]};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == ppc_pkg::BITS_PER_BYTE) begin
              cnt_reg <= 4'h0;
              if (phase_reg == 2'h0) begin
                if (shift_reg[7:1] == DEV_ADDR) begin // R10
                  rw_reg <= shift_reg[0];
                  addr_reg <= ptr_reg;
                  oe_reg <= 1'b1;
                  phase_reg <= 2'h1;
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                oe_reg <= 1'b1;
                state_reg <= ST_ACK;
                if (phase_reg == 2'h1) begin
                  ptr_reg <= shift_reg;
                  phase_reg <= 2'h2;
                end else begin
                  wr_reg <= 1'b1;
                  addr_reg <= ptr_reg;
                  wdata_reg <= shift_reg;
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                shift_reg <= bus.rdata;
                oe_reg <= ~bus.rdata[7];
                cnt_reg <= 4'h1;
                addr_reg <= addr_reg + 8'h01;
                ptr_reg <= addr_reg + 8'h01;
                state_reg <= ST_TX;
              end else begin
                oe_reg <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_reg == ppc_pkg::BITS_PER_BYTE) begin
                oe_reg <= 1'b0;
                state_reg <= ST_TXACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                oe_reg <= ~shift_reg[6];
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              nack_reg <= sda_reg[1];
            end else if (scl_fall) begin
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                shift_reg <= bus.rdata;
                oe_reg <= ~bus.rdata[7];
                cnt_reg <= 4'h1;
                addr_reg <= addr_reg + 8'h01;
                ptr_reg <= addr_reg + 8'h01;
                state_reg <= ST_TX;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign bus.wr_en = wr_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
endmodule // ppc_i2c_target

// ===== verif/ppc_host_model.sv
module ppc_host_model (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 10;
  localparam logic [7:0] ADDR_W = {ppc_pkg::DEV_ADDR_DFLT, 1'b0};
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // ****************************************
  // bit level, every change just after an edge
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // open drain: a released line floats high through the pull-up
  task automatic bit_io(input logic b, output logic seen);
    sda_low_o = ~b;
    wt(HALF / 2);
    scl_o = 1'b1;
    wt(HALF / 2);
    seen = sda_i;
    wt(HALF / 2);
    scl_o = 1'b0;
    wt(HALF / 2);
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    wt(HALF / 2);
    scl_o = 1'b1;
    wt(HALF);
    sda_low_o = 1'b1;
    wt(HALF);
    scl_o = 1'b0;
    wt(HALF / 2);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    wt(HALF / 2);
    scl_o = 1'b1;
    wt(HALF);
    sda_low_o = 1'b0;
    wt(HALF);
  endtask
  // ****************************************
  // byte and transfer level
  // ****************************************
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // single byte reads only, so the answer is always a nack
  task automatic rx(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    tx(ADDR_W, a0);
    tx(ptr, a1);
    tx(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    tx(ADDR_W, a0);
    tx(ptr, a1);
    start();
    tx(ADDR_W | 8'h01, a2);
    rx(d);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // ppc_host_model

// ===== verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, scl, host_low, sda_o, sda_oe, sda_line;
  logic sc_cmp, dis_oc_cmp, chg_oc_cmp, ld_low, th_low, wake_in, nw, ok, pol;
  logic dis_drv, chg_drv, ldmon_en, tsup, ot, wk_st, wk_ev, sc_f, dis_oc_f, chg_oc_f, ldf;
  logic [3:0] mux_sel, m;
  logic [1:0] trip;
  logic [7:0] rd;
  int err_count = 0;
  int tests_run = 0;
  int wk_cnt = 0;
  int seed, base, exp_cnt;
  assign sda_line = (host_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
  ppc_protect_ctrl ppc_protect_ctrl_i (.sys_clk_i(sys_clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .short_circuit_cmp_i(sc_cmp), .discharge_overcurrent_cmp_i(dis_oc_cmp),
    .charge_overcurrent_cmp_i(chg_oc_cmp), .load_monitor_input_low_i(ld_low), .thermistor_input_low_i(th_low),
    .wake_input_i(wake_in), .discharge_switch_drive_o(dis_drv), .charge_switch_drive_o(chg_drv),
    .load_monitor_enable_o(ldmon_en), .analog_mux_select_o(mux_sel), .thermistor_supply_out_o(tsup),
    .discharge_trip_level_o(trip), .over_temp_o(ot), .wake_status_o(wk_st), .wake_event_o(wk_ev),
    .short_circuit_flag_o(sc_f), .discharge_overcurrent_flag_o(dis_oc_f),
    .charge_overcurrent_flag_o(chg_oc_f), .load_fail_flag_o(ldf));
  ppc_host_model ppc_host_model_i (.sys_clk_i(sys_clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (wk_ev === 1'b1) begin
      wk_cnt <= wk_cnt + 1;
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic exp_tsup(input logic [3:0] mx, input logic frc);
    return (mx >= ppc_pkg::MUX_TEMP_FIRST) | frc;
  endfunction
  function automatic logic exp_wake(input logic p, input logic lvl);
    return p ? lvl : ~lvl;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
    ppc_host_model_i.wr(ptr, d, ok);
    chk(ok, 1'b1);
    tick(5);
  endtask
  task automatic rd_reg(input logic [7:0] ptr);
    ppc_host_model_i.rd(ptr, rd, ok);
    chk(ok, 1'b1);
    tick(5);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h7728;
    rstn = 1'b0;
    {sc_cmp, dis_oc_cmp, chg_oc_cmp, ld_low, th_low, wake_in} = 6'h00;
    tick(6);
    rstn = 1'b1;
    chk({dis_drv, chg_drv, tsup, sc_f, ldf, sda_oe, trip}, 8'h00);
    tick(3);
    $display("reset test done");
    for (int k = 0; k < 3; k++) begin
      wr_reg(ppc_pkg::REG_CTRL, 8'h03);
      chk({dis_drv, chg_drv}, 2'b11);
      {chg_oc_cmp, dis_oc_cmp, sc_cmp} = 3'b001 << k;
      tick(5);
      chk({dis_drv, chg_drv}, (k == 2) ? 2'b10 : 2'b01);
      chk({chg_oc_f, dis_oc_f, sc_f, tsup}, {3'(3'b001 << k), 1'b1});
      {chg_oc_cmp, dis_oc_cmp, sc_cmp} = 3'b000;
      // load released early: must not clear while monitoring is off
      ld_low = 1'b1;
      wr_reg(ppc_pkg::REG_CTRL, 8'h03);
      chk({dis_drv, chg_drv, chg_oc_f, dis_oc_f, sc_f}, {(k == 2) ? 2'b10 : 2'b01, 3'(3'b001 << k)});
      rd_reg(ppc_pkg::REG_STATUS);
      chk(rd, {3'b001, k < 2, 3'(3'b001 << k)});
      wr_reg(ppc_pkg::REG_STATUS, 8'h07);
      chk({chg_oc_f, dis_oc_f, sc_f, tsup, ldf}, {4'h0, k < 2});
      wr_reg(ppc_pkg::REG_CTRL, 8'h04);
      chk({ldmon_en, ldf}, 2'b10);
      ld_low = 1'b0;
      $display("flag test %0d done", k);
    end
    wr_reg(ppc_pkg::REG_CTRL, 8'h03);
    chk({dis_drv, chg_drv}, 2'b11);
    for (int i = 0; i < 9; i++) begin
      m = (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : (i == 2) ? 4'hF : 4'($random(seed));
      th_low = 1'($random(seed));
      wr_reg(ppc_pkg::REG_MUX, {4'h0, m});
      chk({mux_sel, tsup, ot}, {m, exp_tsup(m, 1'b0), exp_tsup(m, 1'b0) & th_low});
      rd_reg(ppc_pkg::REG_MUX);
      chk(rd, {4'h0, m});
    end
    wr_reg(ppc_pkg::REG_MUX, 8'h00);
    wr_reg(ppc_pkg::REG_CTRL, 8'h0B);
    th_low = 1'b1;
    tick(3);
    chk({tsup, ot}, 2'b11);
    wr_reg(ppc_pkg::REG_CTRL, 8'h03);
    chk({tsup, ot}, 2'b00);
    th_low = 1'b0;
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 4'h3 : 4'($random(seed));
      wr_reg(ppc_pkg::REG_TRIP, {6'h00, m[1:0]});
      chk(trip, m[1:0]);
      rd_reg(ppc_pkg::REG_TRIP);
      chk(rd, {6'h00, m[1:0]});
    end
    // unmapped pointer: write ignored, reads zero
    wr_reg(8'h07, 8'hFF);
    rd_reg(8'h07);
    chk(rd, 8'h00);
    chk({trip, mux_sel}, {m[1:0], 4'h0});
    $display("mux test done");
    ppc_host_model_i.start();
    ppc_host_model_i.tx({~ppc_pkg::DEV_ADDR_DFLT, 1'b0}, ok);
    ppc_host_model_i.stop();
    chk(ok, 1'b0);
    $display("address test done");
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      wr_reg(ppc_pkg::REG_CTRL, {3'b000, pol, 4'h0});
      base = wk_cnt;
      exp_cnt = 0;
      for (int j = 0; j < 10; j++) begin
        nw = (j < 2) ? ~wake_in : 1'($random(seed));
        if (nw !== wake_in && exp_wake(pol, nw)) begin
          exp_cnt++;
        end
        wake_in = nw;
        tick(5);
        chk(wk_st, exp_wake(pol, nw));
      end
      chk(8'(wk_cnt - base), 8'(exp_cnt));
      $display("wake test %0d done", p);
    end
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule // tb_top
